// ---- rtl/uid_pkg.sv ----
/*
  Shared constants for the serial channel interrupt and DMA signalling block.
  Assumes a 32-bit AXI4-Lite register bus and a 16-deep transmit and receive queue.
*/
package uid_pkg;
  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_IDENT   = 8'h00;  // Read: identification, write: FIFO control.
  localparam logic [7:0] OFS_ENABLE  = 8'h04;  // Interrupt enable.
  localparam logic [7:0] OFS_STATUS  = 8'h08;  // Control and pending readback.
  // ----------------------------------------------------------------------
  // FIFO control field positions
  // ----------------------------------------------------------------------
  localparam int FC_FIFO_EN   = 0;
  localparam int FC_RX_CLR    = 1;
  localparam int FC_TX_CLR    = 2;
  localparam int FC_DMA_SEL   = 3;
  localparam int FC_TRIG_LO   = 6;
  localparam int FC_TRIG_HI   = 7;
  // ----------------------------------------------------------------------
  // Interrupt enable field positions, enable and trigger reset values
  // ----------------------------------------------------------------------
  localparam int IE_RX_DATA   = 0;
  localparam int IE_TX_EMPTY  = 1;
  localparam int IE_LINE      = 2;
  localparam int IE_MODEM     = 3;
  localparam logic [3:0] IE_RESET    = 4'h0;
  localparam logic [1:0] TRIG_RESET  = 2'h0;
  // ----------------------------------------------------------------------
  // Identification codes, bits 3..0
  // ----------------------------------------------------------------------
  localparam logic [3:0] ID_NONE     = 4'h1;
  localparam logic [3:0] ID_LINE     = 4'h6;
  localparam logic [3:0] ID_RX_DATA  = 4'h4;
  localparam logic [3:0] ID_TIMEOUT  = 4'hC;
  localparam logic [3:0] ID_TX_EMPTY = 4'h2;
  localparam logic [3:0] ID_MODEM    = 4'h0;
  // ----------------------------------------------------------------------
  // Queue sizes, trigger levels and timing
  // ----------------------------------------------------------------------
  localparam logic [4:0] QUEUE_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_L0     = 5'h01;
  localparam logic [4:0] TRIG_L1     = 5'h04;
  localparam logic [4:0] TRIG_L2     = 5'h08;
  localparam logic [4:0] TRIG_L3     = 5'h0E;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;  // Character times without activity.
  // ----------------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uid_pkg

// ---- rtl/uid_irq_dma.sv ----
/*
  Interrupt prioritisation, identification and DMA request signalling for one
  serial channel, with an AXI4-Lite register slave.
  Assumes the queue counts, event pulses and access strobes come from logic on
  the same clock, so none of them is synchronised here.
*/
// Local design decisions: the address map and the AXI4-Lite slave port.
// Overview of operation
// - DMA mode one: receive request at trigger/timeout.
// - Mode one receive request holds until queue empty.
// - Mode zero: transmit request while transmit side empty.
// - Mode zero transmit request drops on first write.
// - Mode one transmit request: empty on, full off.
// - FIFO control bits four, five are ignored.
// - Upper control bits pick 1/4/8/14 trigger.
// - Priority: line, receive data, transmit, modem.
// - Identification frozen during read, events still caught.
// - Identification bit zero low when pending.
// - Bit three marks timeout, FIFO mode only.
// - Bits four, five zero; six, seven show FIFO.
// - Line status: error sets, line read clears.
// - Receive data: level set, drops below trigger.
// - Timeout: four idle character times, buffer read clears.
// - Transmit empty cleared by identification read or write.
// - Modem status: changes set, status read clears.
// - Disabled sources hidden from identification and output.
// - Enable bits: receive, transmit, line, modem.
// - Enable bits four to seven read zero.
// - Control bits take effect only with bit zero.
// - Mode zero receive request while any character held.
`timescale 1ns/1ps
`default_nettype none
module uid_irq_dma
  import uid_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // Queue state from the data path
  input  wire logic [4:0]  rxCount,
  input  wire logic [4:0]  txCount,
  input  wire logic        charTick,
  // Event and access pulses from the data path
  input  wire logic        lineErrorEvent,
  input  wire logic        modemChangeEvent,
  input  wire logic        lineStatusRead,
  input  wire logic        modemStatusRead,
  input  wire logic        rxBufferRead,
  input  wire logic        txHoldWrite,
  // Outputs
  output var  logic        interruptOut,
  output var  logic        rxDmaRequestN,
  output var  logic        txDmaRequestN,
  output var  logic        fifoEnableOut,
  output var  logic        rxQueueClear,
  output var  logic        txQueueClear
);
  import uid_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Receive trigger threshold from the two selector bits.
  function automatic logic [4:0] triggerLevel(input logic [1:0] sel);
    unique case (sel)
      2'h0: triggerLevel = TRIG_L0;
      2'h1: triggerLevel = TRIG_L1;
      2'h2: triggerLevel = TRIG_L2;
      2'h3: triggerLevel = TRIG_L3;
    endcase
  endfunction : triggerLevel

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [7:0]  awAddr_q;
  logic        awHave_q;
  logic [31:0] wData_q;
  logic        wLane0_q;
  logic        wHave_q;
  logic        doWrite;
  logic        doRead;
  logic [3:0]  ier_q;
  logic        fifoEn_q;
  logic        dmaSel_q;
  logic [1:0]  trigSel_q;
  logic [3:0]  idCode;
  logic [3:0]  idShown_q;
  logic        linePend_q;
  logic        modemPend_q;
  logic        thrPend_q;
  logic        toPend_q;

  assign doWrite = awHave_q && wHave_q && !bvalid;
  assign doRead  = arvalid && arready;

  // Address and data are captured separately so either may arrive first.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      awready  <= 1'b1;
    end else if (awvalid && awready) begin
      awHave_q <= 1'b1;
      awAddr_q <= awaddr;
      awready  <= 1'b0;
    end else if (doWrite) begin
      awHave_q <= 1'b0;
      awready  <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wHave_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wLane0_q <= 1'b0;
      wready   <= 1'b1;
    end else if (wvalid && wready) begin
      wHave_q  <= 1'b1;
      wData_q  <= wdata;
      wLane0_q <= wstrb[0];
      wready   <= 1'b0;
    end else if (doWrite) begin
      wHave_q <= 1'b0;
      wready  <= 1'b1;
    end
  end

  // Write response; unmapped offsets answer with a slave error.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= (awAddr_q == OFS_IDENT || awAddr_q == OFS_ENABLE ||
                 awAddr_q == OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Interrupt enable; only the low four bits exist.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ier_q <= IE_RESET;
    end else if (doWrite && wLane0_q && awAddr_q == OFS_ENABLE) begin
      ier_q <= wData_q[3:0];
    end
  end

  // FIFO control. With bit zero low, the other fields are not programmed.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fifoEn_q  <= 1'b0;
      dmaSel_q  <= 1'b0;
      trigSel_q <= TRIG_RESET;
    end else if (doWrite && wLane0_q && awAddr_q == OFS_IDENT) begin
      fifoEn_q <= wData_q[FC_FIFO_EN];
      if (wData_q[FC_FIFO_EN]) begin
        dmaSel_q  <= wData_q[FC_DMA_SEL];
        trigSel_q <= {wData_q[FC_TRIG_HI], wData_q[FC_TRIG_LO]};
      end
      // Bits four and five have no destination at all.
    end
  end

  // Queue clear pulses: on explicit request or when FIFO mode toggles.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxQueueClear <= 1'b0;
      txQueueClear <= 1'b0;
    end else if (doWrite && wLane0_q && awAddr_q == OFS_IDENT) begin
      rxQueueClear <= (wData_q[FC_FIFO_EN] & wData_q[FC_RX_CLR]) |
                      (wData_q[FC_FIFO_EN] ^ fifoEn_q);
      txQueueClear <= (wData_q[FC_FIFO_EN] & wData_q[FC_TX_CLR]) |
                      (wData_q[FC_FIFO_EN] ^ fifoEn_q);
    end else begin
      rxQueueClear <= 1'b0;
      txQueueClear <= 1'b0;
    end
  end

  // Read channel. The identification byte is taken from the held copy at
  // the handshake, so it cannot shift while the access is in progress.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (doRead) begin
      rvalid  <= 1'b1;
      arready <= 1'b0;
      rresp   <= RESP_OKAY;
      unique case (araddr)
        OFS_IDENT:  rdata <= {24'h00_0000, fifoEn_q, fifoEn_q, 2'h0, idShown_q};
        OFS_ENABLE: rdata <= {28'h000_0000, ier_q};
        OFS_STATUS: rdata <= {16'h0000, 4'h0, linePend_q, toPend_q, thrPend_q,
                              modemPend_q, trigSel_q, 2'h0, dmaSel_q, 2'h0, fifoEn_q};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------------
  logic       idRead;
  logic       rxAtTrigger;
  logic       rxDataLevel;
  logic [4:0] rxPrev_q;
  logic [2:0] idleChars_q;
  logic       txEmpty;
  logic       txEmptyPrev_q;

  assign idRead      = doRead && araddr == OFS_IDENT;
  assign rxAtTrigger = rxCount >= triggerLevel(trigSel_q);
  assign rxDataLevel = fifoEn_q ? rxAtTrigger : (rxCount != 5'h00);
  assign txEmpty     = txCount == 5'h00;

  // Sticky error flags: a new event in the clearing cycle wins.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      linePend_q <= 1'b0;
    end else if (lineErrorEvent) begin
      linePend_q <= 1'b1;
    end else if (lineStatusRead) begin
      linePend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      modemPend_q <= 1'b0;
    end else if (modemChangeEvent) begin
      modemPend_q <= 1'b1;
    end else if (modemStatusRead) begin
      modemPend_q <= 1'b0;
    end
  end

  // Transmit empty raised on the empty edge; cleared by a write or by an
  // identification read that reports it.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txEmptyPrev_q <= 1'b1;
      thrPend_q     <= 1'b0;
    end else begin
      txEmptyPrev_q <= txEmpty;
      if (txEmpty && !txEmptyPrev_q) begin
        thrPend_q <= 1'b1;
      end else if (txHoldWrite || (idRead && idShown_q == ID_TX_EMPTY)) begin
        thrPend_q <= 1'b0;
      end
    end
  end

  // Idle character counter for the receive timeout.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxPrev_q    <= 5'h00;
      idleChars_q <= 3'h0;
      toPend_q    <= 1'b0;
    end else begin
      rxPrev_q <= rxCount;
      if (rxCount == 5'h00 || rxCount != rxPrev_q || rxBufferRead) begin
        idleChars_q <= 3'h0;
        if (rxBufferRead || rxCount == 5'h00) begin
          toPend_q <= 1'b0;
        end
      end else if (charTick && idleChars_q != TIMEOUT_CHARS) begin
        idleChars_q <= idleChars_q + 3'h1;
        if (idleChars_q + 3'h1 == TIMEOUT_CHARS) begin
          toPend_q <= fifoEn_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Prioritisation and identification
  // ----------------------------------------------------------------------
  logic lineAct;
  logic dataAct;
  logic toAct;
  logic thrAct;
  logic modemAct;

  // Masked sources; the status flags above keep running regardless.
  assign lineAct  = ier_q[IE_LINE] & linePend_q;
  assign dataAct  = ier_q[IE_RX_DATA] & rxDataLevel;
  assign toAct    = ier_q[IE_RX_DATA] & toPend_q & fifoEn_q;
  assign thrAct   = ier_q[IE_TX_EMPTY] & thrPend_q;
  assign modemAct = ier_q[IE_MODEM] & modemPend_q;

  // Fixed priority; timeout shares second level and is reported first.
  always_comb begin
    if (lineAct) begin
      idCode = ID_LINE;
    end else if (toAct) begin
      idCode = ID_TIMEOUT;
    end else if (dataAct) begin
      idCode = ID_RX_DATA;
    end else if (thrAct) begin
      idCode = ID_TX_EMPTY;
    end else if (modemAct) begin
      idCode = ID_MODEM;
    end else begin
      idCode = ID_NONE;
    end
  end

  // Held copy of the code; it is not updated in the read handshake cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idShown_q <= ID_NONE;
    end else if (!idRead) begin
      idShown_q <= idCode;
    end
  end

  // Interrupt line, a registered level.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interruptOut <= 1'b0;
    end else begin
      interruptOut <= idCode != ID_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // DMA request pins
  // ----------------------------------------------------------------------
  logic dmaMode;
  assign dmaMode = fifoEn_q & dmaSel_q;

  // Receive request, active low. Mode one latches until the queue drains.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxDmaRequestN <= 1'b1;
    end else if (!dmaMode) begin
      rxDmaRequestN <= rxCount == 5'h00;
    end else if (rxCount == 5'h00) begin
      rxDmaRequestN <= 1'b1;
    end else if (rxAtTrigger || toPend_q) begin
      rxDmaRequestN <= 1'b0;
    end
  end

  // Transmit request, active low. Mode one releases only on a full queue,
  // which lets a DMA burst refill the whole queue in one go.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txDmaRequestN <= 1'b1;
    end else if (!dmaMode) begin
      txDmaRequestN <= !txEmpty;
    end else if (txEmpty) begin
      txDmaRequestN <= 1'b0;
    end else if (txCount == QUEUE_DEPTH) begin
      txDmaRequestN <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fifoEnableOut <= 1'b0;
    end else begin
      fifoEnableOut <= fifoEn_q;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_line_sets: assert property (lineErrorEvent |=> linePend_q)
    else $error("line status flag not set by error");
  a_modem_clear: assert property (modemStatusRead && !modemChangeEvent |=> !modemPend_q)
    else $error("modem flag not cleared by status read");
  a_line_prio: assert property (lineAct |-> ##1 idShown_q == ID_LINE || $past(idRead))
    else $error("line status not reported first");
  a_id_frozen: assert property (idRead |=> idShown_q == $past(idShown_q))
    else $error("identification changed during read");
  a_irq_level: assert property (##1 interruptOut == ($past(idCode) != ID_NONE))
    else $error("interrupt output disagrees with pending");
  a_masked_off: assert property (ier_q == 4'h0 |=> !interruptOut)
    else $error("interrupt with all sources disabled");
  a_ier_upper: assert property (rvalid && $past(doRead && araddr == OFS_ENABLE)
                                |-> rdata[31:4] == 28'h000_0000)
    else $error("enable upper bits not zero");
  a_rx_mode0: assert property (!dmaMode && rxCount != 5'h00 |=> !rxDmaRequestN)
    else $error("receive request missing in mode zero");
  a_rx_mode1_hold: assert property (dmaMode && !rxDmaRequestN && rxCount != 5'h00
                                    && $stable(dmaMode) |=> !rxDmaRequestN)
    else $error("mode one receive request dropped early");
  a_tx_mode1: assert property (dmaMode && txEmpty |=> !txDmaRequestN)
    else $error("transmit request missing on empty queue");
  a_thr_clear: assert property (txHoldWrite && !(txEmpty && !txEmptyPrev_q) |=> !thrPend_q)
    else $error("transmit empty not cleared by write");
  a_fc_gate: assert property (doWrite && wLane0_q && awAddr_q == OFS_IDENT
                              && !wData_q[FC_FIFO_EN] |=> $stable(trigSel_q))
    else $error("control programmed without enable bit");

  c_timeout: cover property (toAct ##1 idShown_q == ID_TIMEOUT);
  c_rx_dma1: cover property (dmaMode && !rxDmaRequestN ##[1:40] rxDmaRequestN);
  c_tx_full: cover property (dmaMode && txCount == QUEUE_DEPTH ##1 txDmaRequestN);
  c_thr_read: cover property (idRead && idShown_q == ID_TX_EMPTY);
endmodule : uid_irq_dma
`default_nettype wire

// ---- tb/uid_far_model.sv ----
/*
  Far-side model: receive and transmit queue counters and a character clock.
  Assumes one-cycle command pulses from the bench on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module uid_far_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Push rx, pop rx, push tx, pop tx; queue clears
  input  wire logic [3:0] cmd,
  input  wire logic       rxQueueClear,
  input  wire logic       txQueueClear,
  // Data path view
  output var  logic [4:0] rxCount,
  output var  logic [4:0] txCount,
  output var  logic       charTick
);
  logic [2:0] tick_q;
  // Queue levels; a clear wins, as the device empties the queue.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxCount <= 5'h00;
      txCount <= 5'h00;
    end else begin
      if (rxQueueClear) rxCount <= 5'h00;
      else if (cmd[0] && rxCount < 5'h10) rxCount <= rxCount + 5'h01;
      else if (cmd[1] && rxCount != 5'h00) rxCount <= rxCount - 5'h01;
      if (txQueueClear) txCount <= 5'h00;
      else if (cmd[2] && txCount < 5'h10) txCount <= txCount + 5'h01;
      else if (cmd[3] && txCount != 5'h00) txCount <= txCount - 5'h01;
    end
  end
  // Character time shortened to 8 clocks to keep timeouts short.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) tick_q <= 3'h0;
    else tick_q <= tick_q + 3'h1;
  end
  assign charTick = (tick_q == 3'h7);
endmodule : uid_far_model
`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench: AXI4-Lite master tasks and far-side model.
  Assumes the design answers every access within 100 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uid_pkg::*;
  logic        clock = 1'b0, rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cmd = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rdQ;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, respQ;
  logic [4:0]  rxCount, txCount;
  logic        awready, wready, bvalid, arready, rvalid, charTick, interruptOut;
  logic        rxDmaRequestN, txDmaRequestN, rxQueueClear, txQueueClear, fifoEnOut;
  int          error_cnt = 0, n_tests = 0, i, lv;
  always #2 clock = ~clock;
  uid_irq_dma u_dut (
    .clock, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rxCount, .txCount, .charTick, .lineErrorEvent(cmd[4]),
    .modemChangeEvent(cmd[5]), .lineStatusRead(cmd[6]), .modemStatusRead(cmd[7]),
    .rxBufferRead(cmd[1]), .txHoldWrite(cmd[2]), .interruptOut, .rxDmaRequestN,
    .txDmaRequestN, .fifoEnableOut(fifoEnOut), .rxQueueClear, .txQueueClear);
  uid_far_model u_far (.clock, .rstn, .cmd(cmd[3:0]), .rxQueueClear, .txQueueClear,
    .rxCount, .txCount, .charTick);
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic pin(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : pin
  // Address and data go out together; each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (bvalid !== 1'b1 && t < 100);
    // A write that never gets its response is a mismatch, not a silent exit.
    if (bvalid !== 1'b1) begin
      $display("[ERR] bvalid expected 1 seen %b", bvalid);
      error_cnt++;
    end
    respQ = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      t++;
    end while (rvalid !== 1'b1 && t < 100);
    // A read that never gets its data is a mismatch, not a silent exit.
    if (rvalid !== 1'b1) begin
      $display("[ERR] rvalid expected 1 seen %b", rvalid);
      error_cnt++;
    end
    rdQ   = rdata;
    respQ = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic id(input logic [7:0] e);
    rd(OFS_IDENT);
    chk("ident", {24'h0, e}, rdQ);
  endtask : id
  // Pulses command bit k on n cycles in a row, then lets flags settle.
  task automatic op(input int k, input int n);
    int j;
    for (j = 0; j < n; j++) begin
      @(posedge clock);
      cmd <= 8'h01 << k;
    end
    @(posedge clock);
    cmd <= 8'h00;
    repeat (3) @(posedge clock);
  endtask : op
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    id(8'h01);
    wr(OFS_ENABLE, 32'hFF);
    rd(OFS_ENABLE);
    chk("enable", 32'h0F, rdQ);
    rd(8'h0C);
    chk("rresp", 32'h2, {30'h0, respQ});
    wr(8'h0C, 32'h00);
    chk("bresp", 32'h2, {30'h0, respQ});
    wr(OFS_ENABLE, 32'h00);
    wr(OFS_IDENT, 32'h08);
    rd(OFS_STATUS);
    chk("dmaSel", 32'h0, rdQ & 32'h08);
    pin("fifoEn", 1'b0, fifoEnOut);
    $display("test registers done");
    pin("txReq", 1'b0, txDmaRequestN);
    op(2, 1);
    pin("txReq", 1'b1, txDmaRequestN);
    op(3, 1);
    op(0, 1);
    pin("rxReq", 1'b0, rxDmaRequestN);
    op(1, 1);
    pin("rxReq", 1'b1, rxDmaRequestN);
    $display("test mode zero done");
    // Reserved control bits written as ones must not show.
    wr(OFS_IDENT, 32'h79);
    rd(OFS_STATUS);
    chk("ctrl", 32'h49, rdQ & 32'hFF);
    pin("fifoEn", 1'b1, fifoEnOut);
    wr(OFS_ENABLE, 32'h01);
    for (i = 0; i < 4; i++) begin
      lv = (i == 0) ? 1 : (i == 1) ? 4 : (i == 2) ? 8 : 14;
      wr(OFS_IDENT, {24'h0, 2'(i), 6'h0B});
      op(0, lv - 1);
      id(8'hC1);
      pin("rxReq", 1'b1, rxDmaRequestN);
      op(0, 1);
      id(8'hC4);
      pin("rxReq", 1'b0, rxDmaRequestN);
      pin("irq", 1'b1, interruptOut);
      op(1, 1);
      id(8'hC1);
      pin("rxReq", lv == 1, rxDmaRequestN);
    end
    $display("test trigger levels done");
    wr(OFS_IDENT, 32'hCB);
    op(0, 1);
    repeat (60) @(posedge clock);
    id(8'hCC);
    pin("rxReq", 1'b0, rxDmaRequestN);
    op(1, 1);
    id(8'hC1);
    $display("test timeout done");
    pin("txReq", 1'b0, txDmaRequestN);
    op(2, 15);
    pin("txReq", 1'b0, txDmaRequestN);
    op(2, 1);
    pin("txReq", 1'b1, txDmaRequestN);
    op(3, 16);
    $display("test mode one transmit done");
    wr(OFS_ENABLE, 32'h0F);
    op(4, 1);
    op(5, 1);
    id(8'hC6);
    op(6, 1);
    id(8'hC2);
    id(8'hC0);
    op(7, 1);
    id(8'hC1);
    pin("irq", 1'b0, interruptOut);
    $display("test priority done");
    wr(OFS_ENABLE, 32'h00);
    op(4, 1);
    id(8'hC1);
    pin("irq", 1'b0, interruptOut);
    wr(OFS_ENABLE, 32'h04);
    id(8'hC6);
    pin("irq", 1'b1, interruptOut);
    op(6, 1);
    id(8'hC1);
    // A transmit clear empties one queued character, so the empty flag rises.
    op(2, 1);
    wr(OFS_IDENT, 32'hCD);
    rd(OFS_STATUS);
    chk("txClear", 32'h200, rdQ & 32'h200);
    $display("test masking done");
    results();
  end
  // Watchdog: the tests need well under 5000 cycles.
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    results();
  end
endmodule : tb
`default_nettype wire
